// File: src/system_handler_ctrl_state_reg.sv
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`include "shcs_map.svh"

module system_handler_ctrl_state_reg
  import shcs_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  // axi4-lite write address and data
  input  wire logic [`SHCS_ADDR_W-1:0]  awaddr,
  input  wire logic [2:0]               awprot,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  // axi4-lite write response
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  // axi4-lite read
  input  wire logic [`SHCS_ADDR_W-1:0]  araddr,
  input  wire logic [2:0]               arprot,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  // exception logic side
  input  wire logic                     nonsecure_fault_targeting_control,
  input  wire shcs_pkg::shcs_bits_t     exc_set_s,
  input  wire shcs_pkg::shcs_bits_t     exc_set_ns,
  input  wire shcs_pkg::shcs_bits_t     exc_clr_s,
  input  wire shcs_pkg::shcs_bits_t     exc_clr_ns,
  input  wire logic [3:0]               fault_occur,
  input  wire logic                     fault_to_ns,
  // state toward the exception logic
  output shcs_pkg::shcs_bits_t          state_secure,
  output shcs_pkg::shcs_bits_t          state_nonsecure,
  output logic                          hard_fault_ns_may_preempt,
  output logic                          fault_escalated
);
  import shcs_pkg::*;

  localparam int EN_POS [4] = '{`SHCS_MM_EN, `SHCS_BF_EN,
                                `SHCS_UF_EN, `SHCS_SF_EN};
  localparam int PEND_POS [4] = '{`SHCS_MM_PEND, `SHCS_BF_PEND,
                                  `SHCS_UF_PEND, `SHCS_SF_PEND};

  shcs_state_t q;
  shcs_state_t n;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        ctrl;

  assign ctrl    = nonsecure_fault_targeting_control;
  assign awready = !q.aw_got && !q.bvalid;
  assign wready  = !q.w_got && !q.bvalid;
  assign arready = !q.rvalid;
  assign aw_hs   = awvalid && awready;
  assign w_hs    = wvalid && wready;
  assign ar_hs   = arvalid && arready;

  function automatic logic hit(input logic [`SHCS_ADDR_W-1:0] a);
    hit = {a[`SHCS_ADDR_W-1:2], 2'h0} == `SHCS_OFFSET;
  endfunction

  // software view of the register for one security state
  function automatic logic [31:0] view(input logic ns,
                                       input logic [1:0][`SHCS_W-1:0] bk,
                                       input logic en_bus);
    logic [`SHCS_W-1:0] v;
    v = '0;
    if (!ns)
    begin
      v = bk[0] & `SHCS_IMPL_MASK;
    end
    else
    begin
      v = (bk[1] & `SHCS_BANKED_MASK) | (bk[0] & `SHCS_SHARED_MASK);
      if (!en_bus)
      begin
        v = v & ~`SHCS_BUS_MASK;
      end
    end
    view = {10'h000, v};
  endfunction

  always_comb
  begin
    logic [31:0]        smask;
    logic [`SHCS_W-1:0] em0;
    logic [`SHCS_W-1:0] em1;
    logic               tb;
    smask = '0;
    em0   = '0;
    em1   = '0;
    tb    = 1'b0;
    n     = q;
    n.escalated = 1'b0;
    if (aw_hs)
    begin
      n.aw_got = 1'b1;
      n.aw_hit = hit(awaddr);
      n.aw_ns  = awprot[1];
    end
    if (w_hs)
    begin
      n.w_got = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (q.bvalid && bready)
    begin
      n.bvalid = 1'b0;
    end
    // the write lands once address and data are both held
    if (n.aw_got && n.w_got)
    begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = n.aw_hit ? `SHCS_RESP_OKAY : `SHCS_RESP_SLVERR;
      for (int i = 0; i < 4; i++)
      begin
        smask[i*8 +: 8] = {8{n.wstrb[i]}};
      end
      if (n.aw_hit && !n.aw_ns)
      begin
        em0 = smask[`SHCS_W-1:0] & `SHCS_IMPL_MASK;
      end
      else if (n.aw_hit)
      begin
        em1 = smask[`SHCS_W-1:0] & `SHCS_BANKED_MASK;
        em0 = smask[`SHCS_W-1:0] & `SHCS_SHARED_MASK;
        if (!ctrl)
        begin
          em0 = em0 & ~`SHCS_BUS_MASK;
        end
      end
      n.bank[0] = (n.bank[0] & ~em0) | (n.wdata[`SHCS_W-1:0] & em0);
      n.bank[1] = (n.bank[1] & ~em1) | (n.wdata[`SHCS_W-1:0] & em1);
    end
    if (q.rvalid && rready)
    begin
      n.rvalid = 1'b0;
    end
    if (ar_hs)
    begin
      n.rvalid = 1'b1;
      if (hit(araddr))
      begin
        n.rdata = view(arprot[1], q.bank, ctrl);
        n.rresp = `SHCS_RESP_OKAY;
      end
      else
      begin
        n.rdata = 32'h0000_0000;
        n.rresp = `SHCS_RESP_SLVERR;
      end
    end
    // hardware clears, then sets: a set beats any clear or write
    n.bank[0] = (n.bank[0] & ~exc_clr_s) | exc_set_s;
    n.bank[1] = (n.bank[1] & ~exc_clr_ns) | exc_set_ns;
    for (int f = 0; f < 4; f++)
    begin
      if (fault_occur[f])
      begin
        tb = (f == int'(FAULT_SECURE)) ? 1'b0 : fault_to_ns;
        if ((f == int'(FAULT_BUS)) || (f == int'(FAULT_SECURE)))
        begin
          if (q.bank[0][EN_POS[f]])
          begin
            n.bank[0][PEND_POS[f]] = 1'b1;
          end
          else
          begin
            n.bank[tb][`SHCS_HF_PEND] = 1'b1;
            n.escalated = 1'b1;
          end
        end
        else if (q.bank[tb][EN_POS[f]])
        begin
          n.bank[tb][PEND_POS[f]] = 1'b1;
        end
        else
        begin
          n.bank[tb][`SHCS_HF_PEND] = 1'b1;
          n.escalated = 1'b1;
        end
      end
    end
    // one copy of shared bits only, kept in the secure bank
    n.bank[0] = n.bank[0] & `SHCS_IMPL_MASK;
    n.bank[1] = n.bank[1] & `SHCS_BANKED_MASK;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      q        <= '0;
      q.bank   <= {`SHCS_RESET, `SHCS_RESET};
      q.bresp  <= `SHCS_RESP_OKAY;
      q.rresp  <= `SHCS_RESP_OKAY;
    end
    else
    begin
      q <= n;
    end
  end

  assign bvalid          = q.bvalid;
  assign bresp           = q.bresp;
  assign rvalid          = q.rvalid;
  assign rdata           = q.rdata;
  assign rresp           = q.rresp;
  assign state_secure    = q.bank[0];
  assign state_nonsecure = q.bank[1];
  assign fault_escalated = q.escalated;
  // the preemption logic must hold off a non-secure hard fault here while control is low
  assign hard_fault_ns_may_preempt =
    q.bank[1][`SHCS_HF_PEND] && ctrl;

  // checks

  sequence s_wr_both;
    awvalid && awready && wvalid && wready;
  endsequence

  sequence s_resp;
    bvalid && (bresp == `SHCS_RESP_OKAY || bresp == `SHCS_RESP_SLVERR);
  endsequence

  property p_wr_resp;
    @(posedge clk_sys) disable iff (!rst_n)
      s_wr_both |=> s_resp;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response not given one cycle after handshake");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      rvalid |-> (rdata[31:22] == 10'h000) && !rdata[9] && !rdata[6];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_bus_raz;
    @(posedge clk_sys) disable iff (!rst_n)
      (ar_hs && arprot[1] && !ctrl && hit(araddr)) |=>
        !rdata[`SHCS_BF_EN] && !rdata[`SHCS_BF_PEND] && !rdata[`SHCS_BF_ACT];
  endproperty
  a_bus_raz: assert property (p_bus_raz)
    else $error("bus fault bits visible to non-secure read");

  property p_bus_wi;
    @(posedge clk_sys) disable iff (!rst_n)
      (n.aw_got && n.w_got && n.aw_ns && n.aw_hit && !ctrl &&
       !exc_set_s[`SHCS_BF_EN] && !exc_clr_s[`SHCS_BF_EN]) |=>
        $stable(state_secure[`SHCS_BF_EN]);
  endproperty
  a_bus_wi: assert property (p_bus_wi)
    else $error("non-secure write reached bus fault enable");

  property p_escalate;
    @(posedge clk_sys) disable iff (!rst_n)
      (fault_occur[0] && !fault_to_ns && !q.bank[0][`SHCS_MM_EN]) |=>
        state_secure[`SHCS_HF_PEND] && fault_escalated;
  endproperty
  a_escalate: assert property (p_escalate)
    else $error("disabled fault not turned into hard fault");

  property p_pend;
    @(posedge clk_sys) disable iff (!rst_n)
      (fault_occur[2] && fault_to_ns && q.bank[1][`SHCS_UF_EN]) |=>
        state_nonsecure[`SHCS_UF_PEND] && !fault_escalated;
  endproperty
  a_pend: assert property (p_pend)
    else $error("enabled usage fault not pended");

  property p_set_wins;
    @(posedge clk_sys) disable iff (!rst_n)
      (exc_set_ns[`SHCS_TICK_ACT] && exc_clr_ns[`SHCS_TICK_ACT]) |=>
        state_nonsecure[`SHCS_TICK_ACT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a set on tick active");

  property p_single_copy;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_nonsecure & `SHCS_SHARED_MASK) == `SHCS_RESET;
  endproperty
  a_single_copy: assert property (p_single_copy)
    else $error("shared bit held in non-secure bank");

  property p_no_preempt;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_nonsecure[`SHCS_HF_PEND] && !ctrl) |-> !hard_fault_ns_may_preempt;
  endproperty
  a_no_preempt: assert property (p_no_preempt)
    else $error("non-secure hard fault may preempt with control clear");

  property p_rd_resp;
    @(posedge clk_sys) disable iff (!rst_n)
      ar_hs |=> rvalid && !arready;
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read data not given one cycle after handshake");

  // a stalled master must still find the same word
  property p_rd_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data dropped before taken");

  property p_esc_cause;
    @(posedge clk_sys) disable iff (!rst_n)
      fault_escalated |-> $past(fault_occur) != 4'h0;
  endproperty
  a_esc_cause: assert property (p_esc_cause)
    else $error("escalation flagged with no fault");

  property p_sf_pend;
    @(posedge clk_sys) disable iff (!rst_n)
      (fault_occur[3] && state_secure[`SHCS_SF_EN]) |=>
        state_secure[`SHCS_SF_PEND];
  endproperty
  a_sf_pend: assert property (p_sf_pend)
    else $error("enabled secure fault not pended");

  // hardware sets always land, whatever software or a clear did
  property p_set_s;
    @(posedge clk_sys) disable iff (!rst_n)
      (exc_set_s != 22'h00_0000) |=>
        (~state_secure & $past(exc_set_s) & `SHCS_IMPL_MASK) == 22'h00_0000;
  endproperty
  a_set_s: assert property (p_set_s)
    else $error("secure set lost");

  property p_set_ns;
    @(posedge clk_sys) disable iff (!rst_n)
      (exc_set_ns != 22'h00_0000) |=>
        (~state_nonsecure & $past(exc_set_ns) & `SHCS_BANKED_MASK) ==
        22'h00_0000;
  endproperty
  a_set_ns: assert property (p_set_ns)
    else $error("non-secure set lost");

endmodule // system_handler_ctrl_state_reg

// File: shared/shcs_map.svh
`ifndef SHCS_MAP_SVH
`define SHCS_MAP_SVH

`define SHCS_ADDR_W      12
`define SHCS_OFFSET      12'h000
`define SHCS_W           22
`define SHCS_RESET       22'h00_0000
`define SHCS_IMPL_MASK   22'h3f_fdbf
`define SHCS_SHARED_MASK 22'h1a_4132
`define SHCS_BANKED_MASK 22'h25_bc8d
`define SHCS_BUS_MASK    22'h02_4002
`define SHCS_HF_PEND     21
`define SHCS_SF_PEND     20
`define SHCS_SF_EN       19
`define SHCS_UF_EN       18
`define SHCS_BF_EN       17
`define SHCS_MM_EN       16
`define SHCS_SVC_PEND    15
`define SHCS_BF_PEND     14
`define SHCS_MM_PEND     13
`define SHCS_UF_PEND     12
`define SHCS_TICK_ACT    11
`define SHCS_PSV_ACT     10
`define SHCS_MON_ACT     8
`define SHCS_SVC_ACT     7
`define SHCS_NMI_ACT     5
`define SHCS_SF_ACT      4
`define SHCS_UF_ACT      3
`define SHCS_HF_ACT      2
`define SHCS_BF_ACT      1
`define SHCS_MM_ACT      0
`define SHCS_RESP_OKAY   2'h0
`define SHCS_RESP_SLVERR 2'h2

`endif

// File: shared/shcs_pkg.sv
`include "shcs_map.svh"

package shcs_pkg;

  typedef logic [`SHCS_W-1:0] shcs_bits_t;

  // fault source order on fault_occur
  typedef enum logic [1:0]
  {
    FAULT_MEM    = 2'h0,
    FAULT_BUS    = 2'h1,
    FAULT_USAGE  = 2'h2,
    FAULT_SECURE = 2'h3
  } fault_src_t;

  typedef struct packed
  {
    logic                   aw_got;
    logic                   aw_hit;
    logic                   aw_ns;
    logic                   w_got;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [1:0][`SHCS_W-1:0] bank;
    logic                   escalated;
  } shcs_state_t;

endpackage

// File: sim/tb.sv
`include "shcs_map.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import shcs_pkg::*;

  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        ctl = 1'b1;
  shcs_bits_t  exc_set_s = '0, exc_set_ns = '0;
  shcs_bits_t  exc_clr_s = '0, exc_clr_ns = '0;
  logic [3:0]  flt = 4'h0;
  logic        fns = 1'b0;
  shcs_bits_t  st_s, st_ns;
  logic        pre, esc;
  logic        rlate = 1'b0;
  // model of both banks, shared bits held in the secure copy
  shcs_bits_t  sb = '0, nb = '0;
  int          err_total = 0, compares = 0, cyc = 0;

  system_handler_ctrl_state_reg dut
  (
    .clk_sys, .rst_n, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready,
    .nonsecure_fault_targeting_control(ctl), .exc_set_s, .exc_set_ns,
    .exc_clr_s, .exc_clr_ns, .fault_occur(flt), .fault_to_ns(fns),
    .state_secure(st_s), .state_nonsecure(st_ns),
    .hard_fault_ns_may_preempt(pre), .fault_escalated(esc)
  );

  always #25 clk_sys = ~clk_sys;

  // cut a hang short
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // non-secure reach into shared bits, bus bits hidden while control is low
  function automatic shcs_bits_t shm();
    return `SHCS_SHARED_MASK & ~(ctl ? 22'h0 : `SHCS_BUS_MASK);
  endfunction

  function automatic shcs_bits_t upd(shcs_bits_t o, shcs_bits_t d,
                                     shcs_bits_t m);
    return (o & ~m) | (d & m);
  endfunction

  function automatic logic [31:0] view(input logic ns);
    return ns ? {10'h0, (nb & `SHCS_BANKED_MASK) | (sb & shm())}
              : {10'h0, sb};
  endfunction

  task automatic model_wr(input logic [31:0] d, input logic [3:0] s,
                          input logic ns);
    shcs_bits_t m;
    m = {{6{s[2]}}, {8{s[1]}}, {8{s[0]}}} & `SHCS_IMPL_MASK;
    if (!ns)
      sb = upd(sb, d[21:0], m);
    else
    begin
      nb = upd(nb, d[21:0], m & `SHCS_BANKED_MASK);
      sb = upd(sb, d[21:0], m & shm());
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic ns);
    logic ha, hw, dn;
    logic [1:0] r;
    dn = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    awprot <= {1'b0, ns, 1'b0};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!dn)
    begin
      @(negedge clk_sys);
      ha = awvalid && awready;
      hw = wvalid && wready;
      dn = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk_sys);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(r, a == `SHCS_OFFSET ? `SHCS_RESP_OKAY : `SHCS_RESP_SLVERR);
  endtask

  task automatic rd(input logic [11:0] a, input logic ns);
    logic ha, dn, rv;
    logic [31:0] d;
    logic [1:0] r;
    dn = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arprot <= {1'b0, ns, 1'b0};
    arvalid <= 1'b1;
    rready <= !rlate;
    while (!dn)
    begin
      @(negedge clk_sys);
      ha = arvalid && arready;
      rv = (rvalid === 1'b1);
      dn = rv && rready;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ha) arvalid <= 1'b0;
      if (rv && !rready) rready <= 1'b1;
    end
    rready <= 1'b0;
    chk(d, a == `SHCS_OFFSET ? view(ns) : 32'h0);
    chk(r, a == `SHCS_OFFSET ? `SHCS_RESP_OKAY : `SHCS_RESP_SLVERR);
  endtask

  task automatic sst();
    @(negedge clk_sys);
    chk(st_s, sb);
    chk(st_ns, nb & `SHCS_BANKED_MASK);
    chk(pre, nb[21] && ctl);
  endtask

  initial
  begin
    logic [31:0] d;
    logic [3:0] s;
    logic ns, e;
    int src, ei, pi;
    void'($urandom(62));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk({awready, wready, arready, bvalid, rvalid}, 5'h1c);
    rd(`SHCS_OFFSET, 1'b0);
    rd(`SHCS_OFFSET, 1'b1);
    sst();
    $display("test reset done");
    // random words and strobes from both states
    repeat (40)
    begin
      @(posedge clk_sys);
      ns = 1'($urandom);
      ctl <= 1'($urandom);
      d = $urandom;
      s = 4'($urandom);
      wr(`SHCS_OFFSET, d, s, ns);
      model_wr(d, s, ns);
      rd(`SHCS_OFFSET, 1'b0);
      rd(`SHCS_OFFSET, 1'b1);
      sst();
    end
    // unmapped word: refused, nothing written
    wr(12'h004, 32'hffff_ffff, 4'hf, 1'b0);
    rd(12'h004, 1'b0);
    // late ready: the word must stand until taken
    rlate = 1'b1;
    rd(`SHCS_OFFSET, 1'b0);
    rlate = 1'b0;
    $display("test bus done");
    repeat (20)
    begin
      @(posedge clk_sys);
      exc_set_s <= 22'($urandom) & `SHCS_IMPL_MASK;
      exc_clr_s <= 22'($urandom) & `SHCS_IMPL_MASK;
      exc_set_ns <= 22'($urandom) & `SHCS_BANKED_MASK;
      exc_clr_ns <= 22'($urandom) & `SHCS_BANKED_MASK;
      @(posedge clk_sys);
      sb = (sb & ~exc_clr_s) | exc_set_s;
      nb = (nb & ~exc_clr_ns) | exc_set_ns;
      exc_set_s <= '0;
      exc_clr_s <= '0;
      exc_set_ns <= '0;
      exc_clr_ns <= '0;
      sst();
    end
    $display("test exception side done");
    // faults with handler enabled and disabled
    repeat (32)
    begin
      @(posedge clk_sys);
      ctl <= 1'($urandom);
      d = $urandom;
      wr(`SHCS_OFFSET, d, 4'hf, 1'b0);
      model_wr(d, 4'hf, 1'b0);
      d = $urandom;
      wr(`SHCS_OFFSET, d, 4'hf, 1'b1);
      model_wr(d, 4'hf, 1'b1);
      src = int'($urandom_range(3, 0));
      @(posedge clk_sys);
      flt <= 4'h1 << src;
      fns <= 1'($urandom);
      @(posedge clk_sys);
      flt <= 4'h0;
      ei = 16 + src;
      pi = src == 0 ? 13 : src == 1 ? 14 : src == 2 ? 12 : 20;
      ns = fns && src != 3;
      e = (ns && src != 1) ? !nb[ei] : !sb[ei];
      if (e && ns)
        nb[21] = 1'b1;
      else if (e)
        sb[21] = 1'b1;
      else if (ns && src != 1)
        nb[pi] = 1'b1;
      else
        sb[pi] = 1'b1;
      sst();
      chk(esc, e);
      @(negedge clk_sys);
      chk(esc, 1'b0);
    end
    $display("test faults done");
    tally_and_finish();
  end
endmodule // tb
